/* dac_board_update_control.sv */
// Update control for an eight-channel converter board on APB
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module dac_board_update_control
	import dac_update_pkg::*;
#(
	parameter int WIDTH = dac_update_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [dac_update_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Configuration straps
	input  wire logic                      cfgDelayedMode,
	input  wire logic                      cfgTrigEnable,
	// Backplane and field pins
	input  wire logic                      extTrigger_n,
	input  wire logic                      adcEndOfConvert,
	// Converter side
	output logic [dac_update_pkg::CH_COUNT-1:0][WIDTH-1:0] dacWord,
	output logic [dac_update_pkg::CH_COUNT-1:0] dacConvertStart,
	// Routing switches and lamp
	output logic                           fieldOutputEnable,
	output logic                           failLedOn,
	output logic                           testBusOneOutput,
	output logic                           testBusTwoOutput,
	output logic                           senseGroundReturn,
	output logic [dac_update_pkg::CH_SEL_W-1:0] testChannelSel
);

	import dac_update_pkg::*;

	// Pin synchronisers: delayed, trigger, trigger_n, end of convert
	logic [3:0] pinMeta_ff;             // First stage, read by stage two
	logic [3:0] pinSync_ff;             // Second stage, safe to use
	logic [3:0] nxt_pinMeta;            // Raw pin sample
	logic       delayedMode;            // Synchronised delayed strap
	logic       trigEnabled;            // Synchronised trigger strap
	logic       trigLow;                // Trigger pin held low
	logic       eocLevel;               // End of convert level

	// Trigger qualifier and end-of-convert edge
	logic [3:0] trigCnt_ff;             // Cycles trigger seen low
	logic [3:0] nxt_trigCnt;            // Next low count
	logic       eocPrev_ff;             // Last end-of-convert level
	logic       trigFire;               // Qualified trigger event
	logic       eocRise;                // End-of-convert event

	// Bus decode
	logic [6:0] idx;                    // Printed register index
	logic       inRange;                // Upper address bits clear
	logic       isChan;                 // Channel word or byte
	logic       isCsr;                  // Control register
	logic       isStat;                 // Status register
	logic       mapped;                 // Any register hit
	logic [CH_SEL_W-1:0] chSel;         // Addressed channel
	logic       oddByte;                // Odd printed address
	logic       setupRd;                // Read setup phase
	logic       access;                 // Completing access
	logic       wrAcc;                  // Completing mapped write
	logic [31:0] rdVal;                 // Read data mux

	// Bus answer registers
	logic [31:0] prdata_ff;             // Read data
	logic        pready_ff;             // Access-phase ready
	logic        pslverr_ff;            // Unmapped answer
	logic [31:0] nxt_prdata;            // Next read data
	logic        nxt_pready;            // Next ready
	logic        nxt_pslverr;           // Next error

	// Control state
	logic [15:0] csr_ff;                // Stored control bits
	logic [15:0] nxt_csr;               // Next control bits
	logic        startPulse;            // Program start convert
	logic        engaged_ff;            // Test bus currently driven
	logic        nxt_engaged;           // Next engaged state
	logic        bus1_ff;               // Test bus one switch
	logic        bus2_ff;               // Test bus two switch
	logic        nxt_bus1;              // Next bus one switch
	logic        nxt_bus2;              // Next bus two switch
	logic [CH_SEL_W-1:0] testCh_ff;     // Latched channel address
	logic [CH_SEL_W-1:0] nxt_testCh;    // Next channel address
	logic [CH_COUNT-1:0] start_ff;      // Conversion start pulses
	logic [CH_COUNT-1:0] nxt_start;     // Next start pulses

	// Per-channel strobes and contents
	logic [CH_COUNT-1:0] wrLow;         // Low byte write
	logic [CH_COUNT-1:0] wrHigh;        // High byte write
	logic [CH_COUNT-1:0] update;        // Rank transfer
	logic [CH_COUNT-1:0][WIDTH-1:0] firstRank; // Bus-side words

	// Raw pins sampled straight into the first stage
	always_comb begin
		nxt_pinMeta = {adcEndOfConvert, extTrigger_n,
			cfgTrigEnable, cfgDelayedMode};
	end

	// Two-stage synchroniser; trigger idles high after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_ff <= 4'h4;
			pinSync_ff <= 4'h4;
		end else begin
			pinMeta_ff <= nxt_pinMeta;
			pinSync_ff <= pinMeta_ff;
		end
	end

	// Only the second stage is looked at
	assign delayedMode = pinSync_ff[0];
	assign trigEnabled = pinSync_ff[1];
	assign trigLow     = ~pinSync_ff[2];
	assign eocLevel    = pinSync_ff[3];

	// Trigger counts as one event once low for its least time;
	// shorter glitches are ignored, a long low fires only once
	always_comb begin
		nxt_trigCnt = trigCnt_ff;
		trigFire    = 1'b0;
		if (!trigLow) begin
			nxt_trigCnt = 4'h0;
		end else if (trigCnt_ff < TRIG_MIN_CNT) begin
			nxt_trigCnt = trigCnt_ff + 4'h1;
			trigFire    = (trigCnt_ff == TRIG_MIN_CNT - 4'h1);
		end
	end

	// Rising edge of the end-of-convert level
	assign eocRise = eocLevel & ~eocPrev_ff;

	// Trigger counter and edge history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trigCnt_ff <= 4'h0;
			eocPrev_ff <= 1'b0;
		end else begin
			trigCnt_ff <= nxt_trigCnt;
			eocPrev_ff <= eocLevel;
		end
	end

	// Address decode on the printed index
	assign idx     = paddr[IDX_MSB:IDX_LSB];
	assign inRange = (paddr[ADDR_W-1:IDX_MSB+1] == '0)
		&& (paddr[IDX_LSB-1:0] == 2'h0);
	assign isChan  = inRange && (idx[6:4] == CH_BASE_IDX[6:4]);
	assign isCsr   = inRange && (idx[6:4] == CSR_BASE_IDX[6:4]);
	assign isStat  = inRange && (idx == STATUS_IDX);
	assign mapped  = isChan | isCsr | isStat;
	assign chSel   = idx[3:1];
	assign oddByte = idx[0];
	assign setupRd = psel & ~penable & ~pwrite;
	assign access  = psel & penable & pready_ff;
	assign wrAcc   = access & pwrite & mapped;

	// Read mux; reading never touches conversion state
	always_comb begin
		rdVal = 32'h0000_0000;
		if (isCsr) begin
			rdVal = {16'h0000, csr_ff};
		end else if (isChan && oddByte) begin
			rdVal = {24'h00_0000, firstRank[chSel][7:0]};
		end else if (isChan) begin
			rdVal = {16'h0000, firstRank[chSel]};
		end else if (isStat) begin
			rdVal[STAT_DRIVEN_BIT]  = engaged_ff;
			rdVal[STAT_DELAYED_BIT] = delayedMode;
			rdVal[STAT_TRIG_BIT]    = trigEnabled;
		end
	end

	// One wait-free access: ready rises for the access phase only
	always_comb begin
		nxt_pready  = psel & ~penable;
		nxt_pslverr = psel & ~penable & ~mapped;
		nxt_prdata  = prdata_ff;
		if (setupRd) begin
			nxt_prdata = rdVal;
		end
	end

	// Bus answer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Start bit is a pulse, only meaningful under the delayed strap
	assign startPulse = wrAcc & isCsr & pstrb[1]
		& pwdata[CSR_START_BIT] & delayedMode;

	// Channel strobes; bytes may come in either order, but the
	// high byte is what converts in immediate mode
	always_comb begin
		for (int i = 0; i < CH_COUNT; i++) begin
			wrLow[i]  = wrAcc & isChan & (chSel == CH_SEL_W'(i))
				& pstrb[0];
			wrHigh[i] = wrAcc & isChan & (chSel == CH_SEL_W'(i))
				& ~oddByte & pstrb[1];
			update[i] = delayedMode
				? (startPulse | (trigFire & trigEnabled))
				: wrHigh[i];
		end
	end

	// Low byte sits in lane 0 at both even and odd addresses
	generate
		for (genvar g = 0; g < CH_COUNT; g++) begin : gChan
			dac_channel_latch #(
				.WIDTH      (WIDTH)
			) uLatch (
				.clk        (clk),
				.rst_n      (rst_n),
				.wrLow      (wrLow[g]),
				.wrHigh     (wrHigh[g]),
				.dataIn     (pwdata[WIDTH-1:0]),
				.update     (update[g]),
				.firstRank  (firstRank[g]),
				.secondRank (dacWord[g])
			);
		end
	endgenerate

	// Control register, test routing and channel address latch
	always_comb begin
		nxt_csr     = csr_ff;
		nxt_testCh  = testCh_ff;
		nxt_engaged = engaged_ff;
		// Only the high lane carries control bits
		if (wrAcc && isCsr && pstrb[1]) begin
			nxt_csr = pwdata[15:0] & CSR_STORE_MASK;
		end
		// Every channel or control write latches the channel for the test switch
		if (wrAcc && (isChan || isCsr)) begin
			nxt_testCh = chSel;
		end
		// End of convert drops the bus; a write in the same cycle
		// re-engages, so a fresh request is never lost
		if (eocRise) begin
			nxt_engaged = 1'b0;
		end
		if (wrAcc && (isChan || isCsr) && nxt_csr[CSR_ENGAGE_BIT]) begin
			nxt_engaged = 1'b1;
		end
		// Switches follow the routing bits only while engaged
		nxt_bus1 = nxt_engaged & nxt_csr[CSR_ENGAGE_BIT]
			& nxt_csr[CSR_BUS1_BIT];
		nxt_bus2 = nxt_engaged & nxt_csr[CSR_ENGAGE_BIT]
			& nxt_csr[CSR_BUS2_BIT];
		nxt_start = update;
	end

	// Control state registers, all low at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			csr_ff     <= CSR_RESET;
			testCh_ff  <= '0;
			engaged_ff <= 1'b0;
			bus1_ff    <= 1'b0;
			bus2_ff    <= 1'b0;
			start_ff   <= '0;
		end else begin
			csr_ff     <= nxt_csr;
			testCh_ff  <= nxt_testCh;
			engaged_ff <= nxt_engaged;
			bus1_ff    <= nxt_bus1;
			bus2_ff    <= nxt_bus2;
			start_ff   <= nxt_start;
		end
	end

	// Outputs, each straight from a flip-flop except failLedOn, which is inverted
	assign prdata            = prdata_ff;
	assign pready            = pready_ff;
	assign pslverr           = pslverr_ff;
	assign dacConvertStart   = start_ff;
	assign fieldOutputEnable = csr_ff[CSR_FIELD_BIT];
	assign failLedOn         = ~csr_ff[CSR_FAIL_OFF_BIT];
	assign testBusOneOutput  = bus1_ff;
	assign testBusTwoOutput  = bus2_ff;
	assign senseGroundReturn = bus2_ff;
	assign testChannelSel    = testCh_ff;

endmodule : dac_board_update_control

/* dac_update_pkg.sv */
// Shared constants for the converter board update control block
package dac_update_pkg;

	// Geometry of the converter array
	localparam int CH_COUNT = 8;             // Converter channels
	localparam int DATA_W   = 16;            // Converter word width
	localparam int CH_SEL_W = 3;             // Channel select width

	// Register indices; byte address is four times the index
	localparam logic [6:0] CH_BASE_IDX = 7'h60; // Channel 0 word
	localparam logic [6:0] CSR_BASE_IDX = 7'h70; // Channel 0 word + 10h
	localparam logic [6:0] STATUS_IDX = 7'h40; // Live board status

	// APB address field positions
	localparam int IDX_LSB  = 2;             // Index starts above byte bits
	localparam int IDX_MSB  = 8;             // Top of the 7-bit index
	localparam int ADDR_W   = 12;            // APB address width

	// Control and status register fields
	localparam int CSR_FAIL_OFF_BIT = 14;    // Low lights the fail lamp
	localparam int CSR_BUS2_BIT     = 13;    // Route to test bus two
	localparam int CSR_BUS1_BIT     = 12;    // Route to test bus one
	localparam int CSR_ENGAGE_BIT   = 11;    // Engage a test bus
	localparam int CSR_START_BIT    = 9;     // Program start convert
	localparam int CSR_FIELD_BIT    = 8;     // Field output enable
	localparam logic [15:0] CSR_STORE_MASK = 16'h7900; // Stored bits
	localparam logic [15:0] CSR_RESET      = 16'h0000; // All low

	// Status register fields
	localparam int STAT_DRIVEN_BIT  = 0;     // A test bus is driven
	localparam int STAT_DELAYED_BIT = 1;     // Delayed mode strapped
	localparam int STAT_TRIG_BIT    = 2;     // Trigger strapped

	// External trigger qualification
	localparam int CLK_PERIOD_NS  = 20;      // 50 MHz system clock
	localparam int TRIG_MIN_NS    = 150;     // Least low time of trigger
	localparam int TRIG_MIN_CYC   =
		(TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] TRIG_MIN_CNT = 4'(TRIG_MIN_CYC);

endpackage : dac_update_pkg

/* dac_channel_latch.sv */
// Two-rank data latch in front of one converter channel
`timescale 1ns/1ps
module dac_channel_latch #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Bus side
	input  wire logic               wrLow,
	input  wire logic               wrHigh,
	input  wire logic [WIDTH-1:0]   dataIn,
	// Update event
	input  wire logic               update,
	// Latch contents
	output logic      [WIDTH-1:0]   firstRank,
	output logic      [WIDTH-1:0]   secondRank
);

	logic [WIDTH-1:0] firstRank_ff;     // Written by the bus
	logic [WIDTH-1:0] secondRank_ff;    // Feeds the converter
	logic [WIDTH-1:0] nxt_firstRank;    // Next first rank
	logic [WIDTH-1:0] nxt_secondRank;   // Next second rank

	// Byte-wise load of the first rank, update copies it on
	always_comb begin
		nxt_firstRank  = firstRank_ff;
		nxt_secondRank = secondRank_ff;
		// Low byte lane
		if (wrLow) begin
			nxt_firstRank[WIDTH/2-1:0] = dataIn[WIDTH/2-1:0];
		end
		// High byte lane
		if (wrHigh) begin
			nxt_firstRank[WIDTH-1:WIDTH/2] = dataIn[WIDTH-1:WIDTH/2];
		end
		// Copy includes a byte written in the same cycle, so an
		// immediate high-byte write converts the fresh word
		if (update) begin
			nxt_secondRank = nxt_firstRank;
		end
	end

	// Both ranks clear at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			firstRank_ff  <= '0;
			secondRank_ff <= '0;
		end else begin
			firstRank_ff  <= nxt_firstRank;
			secondRank_ff <= nxt_secondRank;
		end
	end

	// Word passes unchanged, any coding is the software's business
	assign firstRank  = firstRank_ff;
	assign secondRank = secondRank_ff;

endmodule : dac_channel_latch

/* dac_board_update_control_chk.sv */
// Port-level checker for the converter board update control
`timescale 1ns/1ps
module dac_board_update_control_chk
	import dac_update_pkg::*;
#(
	parameter int WIDTH = dac_update_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	// APB
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [dac_update_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                       pwdata,
	input  wire logic [3:0]                        pstrb,
	input  wire logic [31:0]                       prdata,
	input  wire logic                              pready,
	input  wire logic                              pslverr,
	// Straps and pins
	input  wire logic                              cfgDelayedMode,
	input  wire logic                              adcEndOfConvert,
	// Converter and routing
	input  wire logic [dac_update_pkg::CH_COUNT-1:0][WIDTH-1:0] dacWord,
	input  wire logic [dac_update_pkg::CH_COUNT-1:0] dacConvertStart,
	input  wire logic                              fieldOutputEnable,
	input  wire logic                              failLedOn,
	input  wire logic                              testBusOneOutput,
	input  wire logic                              testBusTwoOutput,
	input  wire logic                              senseGroundReturn,
	input  wire logic [dac_update_pkg::CH_SEL_W-1:0] testChannelSel
);
	// One clock domain for every property
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Completed writes, split by target
	logic       wrDone;              // Write taken this edge
	logic       anyWr;               // Channel or control write
	logic       chWr;                // Channel write
	logic       ctrlWr;              // Control write with upper lane
	logic       fullWr;              // Whole word to an even index
	logic [2:0] chQ;                 // Channel of previous access
	logic [15:0] wQ;                 // Low half of previous data
	assign wrDone = psel && penable && pready && pwrite;
	assign anyWr  = wrDone && paddr[11:7] == 5'h03;
	assign chWr   = wrDone && paddr[11:6] == 6'h06;
	assign ctrlWr = wrDone && paddr[11:6] == 6'h07 && pstrb[1];
	assign fullWr = chWr && !paddr[2] && pstrb[1:0] == 2'h3;
	// Remember address and data for one-cycle-later checks
	always_ff @(posedge clk) begin
		chQ <= paddr[5:3];
		wQ  <= pwdata[15:0];
	end
	// Exactly one access cycle, no stretching
	AST_ONE_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("access phase length wrong");
	AST_UNMAPPED: assert property (pready && psel && !pwrite &&
		paddr[11:6] == 6'h00 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	AST_IMM_WORD: assert property (fullWr && !cfgDelayedMode &&
		!$past(cfgDelayedMode, 3) |=> dacWord[chQ] == wQ && dacConvertStart[chQ])
		else $error("immediate word not converted");
	AST_DLY_HOLD: assert property (chWr && cfgDelayedMode &&
		$past(cfgDelayedMode, 3) |=> $stable(dacWord))
		else $error("delayed mode converted on data write");
	AST_START_ALL: assert property (ctrlWr && pwdata[9] &&
		cfgDelayedMode && $past(cfgDelayedMode, 3) |=> &dacConvertStart)
		else $error("start bit missed a channel");
	AST_LAMP_FIELD: assert property (ctrlWr |=>
		failLedOn == !wQ[14] && fieldOutputEnable == wQ[8])
		else $error("lamp or field enable wrong");
	AST_BUS_SEL: assert property (ctrlWr && pwdata[11] |=>
		testBusOneOutput == wQ[12] && testBusTwoOutput == wQ[13])
		else $error("test bus selection wrong");
	AST_SENSE: assert property (senseGroundReturn == testBusTwoOutput)
		else $error("sense return not with bus two");
	AST_CH_LATCH: assert property (anyWr |=> testChannelSel == chQ)
		else $error("channel address not latched");
	AST_EOC_OPEN: assert property ($rose(adcEndOfConvert) && !psel |->
		##[1:6] !testBusOneOutput && !testBusTwoOutput)
		else $error("test bus still driven after end of convert");
	// Main scenarios reached
	COV_IMM: cover property (fullWr && !cfgDelayedMode);
	COV_START: cover property (&dacConvertStart);
	COV_EOC: cover property ($rose(adcEndOfConvert));
endmodule : dac_board_update_control_chk

bind dac_board_update_control dac_board_update_control_chk #(.WIDTH(WIDTH)) chk (.*);

/* dac_bus_master.sv */
// APB master standing in for the processor that programs the board
`timescale 1ns/1ps
module dac_bus_master (
	// Clock
	input  wire logic        clk,
	// Request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	// Answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus from time zero
	initial begin
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 12'h0;
		pwdata  = 32'h0;
		pstrb   = 4'h0;
	end
	// One transfer; held until pready, then released with scrambled lines
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q, output logic e);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		paddr   <= ~a;
		pwdata  <= ~d;
		// Idle edge so a following call never double-drives psel
		@(posedge clk);
	endtask : xfer
	// Write, answer dropped
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] q;
		logic        e;
		xfer(1'h1, a, d, s, q, e);
	endtask : wr
endmodule : dac_bus_master

/* tb_top.sv */
// Directed bench for the converter board update control
`timescale 1ns/1ps
module tb_top;
	import dac_update_pkg::*;
	// Clock, reset, straps and pins
	logic        clk, rst_n, cfgDelayedMode, cfgTrigEnable;
	logic        extTrigger_n, adcEndOfConvert;
	// APB between master and board
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	// Board outputs
	logic [CH_COUNT-1:0][DATA_W-1:0] dacWord;
	logic [CH_COUNT-1:0] dacConvertStart;
	logic        fieldOutputEnable, failLedOn, senseGroundReturn;
	logic        testBusOneOutput, testBusTwoOutput;
	logic [CH_SEL_W-1:0] testChannelSel;
	// Bookkeeping
	int          fails = 0;
	int          checksDone = 0;
	logic [31:0] rdata;
	logic        rerr;
	logic [15:0] d;
	logic [15:0] imm [4] = '{16'h4100, 16'h6C00, 16'h5C00, 16'h6D00};
	logic [15:0] dly [4] = '{16'h4300, 16'h6E00, 16'h5E00, 16'h6F00};
	dac_bus_master bus (.*);
	dac_board_update_control uut (.*);
	// 50 MHz clock
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// Word compare
	task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmpVal
	// Flag compare
	task automatic cmpBit(input logic got, input logic exp);
		cmpVal({31'h0, got}, {31'h0, exp});
	endtask : cmpBit
	// Routing outputs implied by a control word
	task automatic route(input logic [15:0] w);
		cmpBit(failLedOn, !w[14]);
		cmpBit(fieldOutputEnable, w[8]);
		cmpBit(testBusOneOutput, w[11] & w[12]);
		cmpBit(testBusTwoOutput, w[11] & w[13]);
	endtask : route
	// Verdict, single exit
	task automatic report_and_stop;
		if (fails == 0 && checksDone > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Hang guard, far beyond the 172 cycles needed
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		rst_n = 1'h0;
		cfgDelayedMode = 1'h0;
		cfgTrigEnable = 1'h0;
		extTrigger_n = 1'h1;
		adcEndOfConvert = 1'h0;
		repeat (16) @(posedge clk);
		// Reset: lamp lit, paths open, ranks clear
		route(16'h0000);
		cmpBit(|dacWord, 1'h0);
		rst_n <= 1'h1;
		@(posedge clk);
		// Immediate: routing word first, then data, odd channels
		for (int i = 0; i < 4; i++) begin
			d = 16'(32'hA5C3 + i * 32'h1111);
			bus.wr(12'(12'h1C8 + 16 * i), {16'h0, imm[i]}, 4'h3);
			bus.wr(12'(12'h188 + 16 * i), {16'h0, d}, 4'h3);
			cmpVal(dacWord[2 * i + 1], d);
			route(imm[i]);
			cmpVal(testChannelSel, 2 * i + 1);
			bus.xfer(1'h0, 12'(12'h1C8 + 16 * i), 0, 0, rdata, rerr);
			cmpVal(rdata, imm[i] & CSR_STORE_MASK);
		end
		// End of convert opens the driven test bus
		adcEndOfConvert <= 1'h1;
		repeat (6) @(posedge clk);
		cmpBit(testBusTwoOutput, 1'h0);
		adcEndOfConvert <= 1'h0;
		// Bytes: low to odd address, convert on high byte
		bus.wr(12'h1A4, 32'h34, 4'h1);
		cmpVal(dacWord[4], 0);
		bus.wr(12'h1A0, 32'h1200, 4'h2);
		cmpVal(dacWord[4], 16'h1234);
		// Lone low byte and start bit both refused in immediate mode
		bus.wr(12'h1A4, 32'h56, 4'h1);
		bus.wr(12'h1E0, 32'h4300, 4'h2);
		cmpVal(dacWord[4], 16'h1234);
		route(16'h4300);
		// Unmapped accesses are refused, the read with zero
		bus.xfer(1'h0, 12'h000, 0, 0, rdata, rerr);
		cmpVal(rdata, 0);
		cmpBit(rerr, 1'h1);
		bus.xfer(1'h1, 12'h000, 32'hFFFF, 4'h3, rdata, rerr);
		cmpBit(rerr, 1'h1);
		// Delayed: data waits in first rank
		cfgDelayedMode <= 1'h1;
		repeat (4) @(posedge clk);
		bus.wr(12'h198, 32'h0F0F, 4'h3);
		cmpVal(dacWord[3], 16'hB6D4);
		// Start bit at channel address plus 10h moves every channel
		for (int j = 0; j < 4; j++) begin
			d = 16'(32'hFFFF - j * 32'h5555);
			bus.wr(12'(12'h180 + 8 * j), {16'h0, d}, 4'h3);
			bus.wr(12'(12'h1C0 + 8 * j), {16'h0, dly[j]}, 4'h2);
			cmpVal(dacWord[j], d);
			cmpVal(dacWord[3], j == 3 ? d : 16'h0F0F);
			route(dly[j]);
		end
		// Trigger ignored while its strap is off
		bus.wr(12'h1B0, 32'h7E57, 4'h3);
		cmpVal(dacWord[6], 0);
		extTrigger_n <= 1'h0;
		repeat (14) @(posedge clk);
		extTrigger_n <= 1'h1;
		repeat (4) @(posedge clk);
		cmpVal(dacWord[6], 0);
		// Enabled: a short glitch does nothing, a full pulse loads
		cfgTrigEnable <= 1'h1;
		repeat (4) @(posedge clk);
		extTrigger_n <= 1'h0;
		repeat (4) @(posedge clk);
		extTrigger_n <= 1'h1;
		repeat (12) @(posedge clk);
		cmpVal(dacWord[6], 0);
		extTrigger_n <= 1'h0;
		repeat (14) @(posedge clk);
		extTrigger_n <= 1'h1;
		cmpVal(dacWord[6], 16'h7E57);
		// Status and first-rank readback leave conversion alone
		bus.xfer(1'h0, 12'h100, 0, 0, rdata, rerr);
		cmpVal(rdata, 32'h0000_0007);
		cmpBit(rerr, 1'h0);
		bus.xfer(1'h0, 12'h1B0, 0, 0, rdata, rerr);
		cmpVal(rdata, 32'h0000_7E57);
		bus.xfer(1'h0, 12'h1B4, 0, 0, rdata, rerr);
		cmpVal(rdata, 32'h0000_0057);
		cmpVal(dacWord[6], 16'h7E57);
		report_and_stop();
	end
endmodule : tb_top
